/* File: rtl/cip_consts.vh */
`ifndef CIP_CONSTS_VH
`define CIP_CONSTS_VH
// ----------------------------------------------------------------
// Bus addressing and register map.
// ----------------------------------------------------------------
`define CIP_TARGET_ADDR 7'h6b
`define CIP_LAST_REG 8'h0b
`define CIP_NUM_REGS 12
`define CIP_INPUT_CTRL_ADDR 8'h00
`define CIP_FAULT_ADDR 8'h09
`define CIP_UNMAPPED_DATA 8'hff
// ----------------------------------------------------------------
// Input control register layout and values, and the reset value of the other registers.
// ----------------------------------------------------------------
`define CIP_HIZ_BIT 7
`define CIP_STAT_SEL_MSB 6
`define CIP_STAT_SEL_LSB 5
`define CIP_ILIM_MSB 4
`define CIP_ILIM_LSB 0
`define CIP_STAT_SEL_OFF 2'h3
`define CIP_INPUT_CTRL_RST 8'h17
`define CIP_OTHER_REG_RST 8'h00
`define CIP_ILIM_SRC_HIGH 5'h04
`define CIP_ILIM_SRC_LOW 5'h17
// ----------------------------------------------------------------
// Fault register layout and clock hold timing.
// ----------------------------------------------------------------
`define CIP_THERM_BIT 0
`define CIP_STRETCH_CYC 4'h3
`endif

/* File: rtl/cip_sync.v */
`timescale 1ns/1ps
module cip_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire mclk,
  input wire rst_n,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

/* File: rtl/cip_fault_latch.v */
`timescale 1ns/1ps
`include "cip_consts.vh"
module cip_fault_latch (
  input wire mclk,
  input wire rst_n,
  input wire [7:0] live_faults,
  input wire therm_fault,
  input wire read_strobe,
  output wire [7:0] fault_value,
  output reg fault_event
);
  reg [7:0] latched;
  reg therm_prev;
  reg read_seen;
  reg armed;
  wire [7:0] live_mask;
  wire new_fault;
  wire all_clear;

  // The thermistor bit never latches; it always mirrors the sense pin.
  assign live_mask = live_faults & ~(8'h01 << `CIP_THERM_BIT);
  assign fault_value = (latched | live_mask) & ~(8'h01 << `CIP_THERM_BIT)
                       | ({7'h00, therm_fault} << `CIP_THERM_BIT);
  assign new_fault = (|(live_mask & ~latched)) | (therm_fault & ~therm_prev);
  assign all_clear = (latched == 8'h00) && (live_mask == 8'h00) && !therm_fault;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      latched <= 8'h00;
      therm_prev <= 1'b0;
      read_seen <= 1'b0;
      armed <= 1'b1;
      fault_event <= 1'b0;
    end else begin
      therm_prev <= therm_fault;
      // A read reloads with present conditions, so a fault arriving in the read cycle survives.
      if (read_strobe) begin
        latched <= live_mask;
      end else begin
        latched <= latched | live_mask;
      end
      fault_event <= armed & new_fault;
      if (armed && new_fault) begin
        armed <= 1'b0;
        read_seen <= 1'b0;
      end else if (!armed && read_seen && all_clear) begin
        armed <= 1'b1;
      end
      if (read_strobe && !armed) begin
        read_seen <= 1'b1;
      end
    end
  end
endmodule

/* File: rtl/cip_i2c_port.v */
`timescale 1ns/1ps
`include "cip_consts.vh"
// Notes on behaviour
// - Data falling while clock high is a start; it opens every transaction.
// - Data rising while clock high is a stop; it ends the transaction.
// - Bytes are eight bits, most significant first, any number per transfer.
// - Every byte is followed by one acknowledge slot.
// - The port may hold the clock low until the next byte is ready.
// - Sender releases data in the ninth pulse; receiver drives it low throughout.
// - First byte after start is a 7-bit address plus direction, one reads.
// - The port answers only to target address 6b hex.
// - An undefined register address is refused and the port goes idle.
// - Multi-byte reads and writes work across registers zero through eleven, except where a burst reaches register nine.
// - Fault register latches faults until read; next read shows present conditions.
// - The thermistor fault bit always shows the live sense pin.
// - The fault register is reached only as the first byte of an access.
// - Input control bit 7 enables high impedance; cleared by reset and watchdog.
// - Bits 6:5 pick status pin function; code 11 floats the pin.
// - Bits 4:0 set input current limit, 100 mA steps plus offset, default 10111.
// - After source detection the limit loads 500 mA if type pin high, else 2.4 A.
// - Reads beyond register eleven return ff hex.
// - No new fault interrupt until the fault register is read and faults clear.
module cip_i2c_port (
  input wire mclk,
  input wire rst_n,
  input wire scl_in,
  output reg scl_out,
  output reg scl_oe,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire thermistor_sense_pin,
  input wire [7:0] fault_conditions,
  input wire source_type_pin,
  input wire source_detect_done,
  input wire watchdog_expired,
  input wire register_reset,
  output wire high_impedance_enable,
  output wire [1:0] status_pin_function_select,
  output reg status_pin_disable,
  output wire [4:0] input_current_limit,
  output wire fault_event,
  output reg bus_busy
);
  // ----------------------------------------------------------------
  // States.
  // ----------------------------------------------------------------
  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_ADDR = 8'h02;
  localparam [7:0] ST_ACK_ADDR = 8'h04;
  localparam [7:0] ST_REGA = 8'h08;
  localparam [7:0] ST_ACK_W = 8'h10;
  localparam [7:0] ST_WDATA = 8'h20;
  localparam [7:0] ST_RDATA = 8'h40;
  localparam [7:0] ST_MACK = 8'h80;

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  reg [7:0] regs [0:`CIP_NUM_REGS-1];
  reg [7:0] next_input_ctrl;
  reg [7:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [7:0] tx;
  reg [7:0] ptr;
  reg rw;
  reg first_data;
  reg load_pending;
  reg mack_ok;
  reg [3:0] stretch_cnt;
  reg wr_en;
  reg [7:0] wr_addr;
  reg [7:0] wr_data;
  reg fault_read;
  reg scl_d;
  reg sda_d;
  wire scl_s;
  wire sda_s;
  wire therm_s;
  wire src_type_s;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire [7:0] fault_value;
  integer i;

  // ----------------------------------------------------------------
  // Functions.
  // ----------------------------------------------------------------
  function reg_defined;
    input [7:0] a;
    begin
      reg_defined = (a <= `CIP_LAST_REG);
    end
  endfunction

  function single_only;
    input [7:0] a;
    input first;
    begin
      single_only = (a == `CIP_FAULT_ADDR) && !first;
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin sampling and bus conditions.
  // ----------------------------------------------------------------
  cip_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_bus_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in({scl_in, sda_in}),
    .sync_out({scl_s, sda_s})
  );

  cip_sync #(.WIDTH(2), .RESET_VAL(2'h0)) u_pin_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in({thermistor_sense_pin, source_type_pin}),
    .sync_out({therm_s, src_type_s})
  );

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------------------------------
  // Fault register.
  // ----------------------------------------------------------------
  cip_fault_latch u_fault (
    .mclk(mclk),
    .rst_n(rst_n),
    .live_faults(fault_conditions),
    .therm_fault(therm_s),
    .read_strobe(fault_read),
    .fault_value(fault_value),
    .fault_event(fault_event)
  );

  // ----------------------------------------------------------------
  // Serial protocol engine.
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      first_data <= 1'b0;
      load_pending <= 1'b0;
      mack_ok <= 1'b0;
      stretch_cnt <= 4'h0;
      wr_en <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      fault_read <= 1'b0;
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      bus_busy <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      fault_read <= 1'b0;
      // The clock is held low only for a fixed CIP_STRETCH_CYC plus one cycles each time a read byte is fetched.
      if (stretch_cnt != 4'h0) begin
        stretch_cnt <= stretch_cnt - 4'h1;
        scl_oe <= 1'b1;
      end else begin
        scl_oe <= 1'b0;
      end
      if (load_pending) begin
        load_pending <= 1'b0;
        bit_cnt <= 4'h0;
        if (!reg_defined(ptr) || single_only(ptr, first_data)) begin
          tx <= `CIP_UNMAPPED_DATA;
          sda_oe <= 1'b0;
        end else if (ptr == `CIP_FAULT_ADDR) begin
          tx <= fault_value;
          sda_oe <= ~fault_value[7];
          fault_read <= 1'b1;
        end else begin
          tx <= regs[ptr[3:0]];
          sda_oe <= ~regs[ptr[3:0]][7];
        end
      end
      if (start_det) begin
        bus_busy <= 1'b1;
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
        stretch_cnt <= 4'h0;
        load_pending <= 1'b0;
      end else if (stop_det) begin
        bus_busy <= 1'b0;
        state <= ST_IDLE;
        sda_oe <= 1'b0;
        stretch_cnt <= 4'h0;
        load_pending <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_ADDR, ST_REGA, ST_WDATA: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              if (state == ST_ADDR) begin
                if (shift[7:1] == `CIP_TARGET_ADDR) begin
                  rw <= shift[0];
                  first_data <= 1'b1;
                  sda_oe <= 1'b1;
                  state <= ST_ACK_ADDR;
                end else begin
                  state <= ST_IDLE;
                end
              end else if (state == ST_REGA) begin
                if (reg_defined(shift)) begin
                  ptr <= shift;
                  first_data <= 1'b1;
                  sda_oe <= 1'b1;
                  state <= ST_ACK_W;
                end else begin
                  state <= ST_IDLE;
                end
              end else begin
                if (reg_defined(ptr)) begin
                  // Writes into the fault register are acknowledged but dropped.
                  wr_en <= (ptr != `CIP_FAULT_ADDR) && !single_only(ptr, first_data);
                  wr_addr <= ptr;
                  wr_data <= shift;
                  ptr <= ptr + 8'h01;
                  first_data <= 1'b0;
                  sda_oe <= 1'b1;
                  state <= ST_ACK_W;
                end else begin
                  state <= ST_IDLE;
                end
              end
            end
          end
          ST_ACK_ADDR: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              if (rw) begin
                load_pending <= 1'b1;
                stretch_cnt <= `CIP_STRETCH_CYC;
                scl_oe <= 1'b1;
                state <= ST_RDATA;
              end else begin
                state <= ST_REGA;
              end
            end
          end
          ST_ACK_W: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              state <= ST_WDATA;
            end
          end
          ST_RDATA: begin
            if (scl_fall && !load_pending) begin
              if (bit_cnt == 4'h7) begin
                sda_oe <= 1'b0;
                state <= ST_MACK;
              end else begin
                sda_oe <= ~tx[6];
                tx <= {tx[6:0], 1'b0};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              mack_ok <= ~sda_s;
            end else if (scl_fall) begin
              if (mack_ok) begin
                ptr <= ptr + 8'h01;
                first_data <= 1'b0;
                load_pending <= 1'b1;
                stretch_cnt <= `CIP_STRETCH_CYC;
                scl_oe <= 1'b1;
                state <= ST_RDATA;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file.
  // ----------------------------------------------------------------
  always @* begin
    next_input_ctrl = regs[0];
    if (wr_en && wr_addr == `CIP_INPUT_CTRL_ADDR) begin
      next_input_ctrl = wr_data;
    end
    // Detection overrides the limit bits 4:0 of a host write landing in the same cycle.
    if (source_detect_done) begin
      next_input_ctrl[`CIP_ILIM_MSB:`CIP_ILIM_LSB] = src_type_s ? `CIP_ILIM_SRC_HIGH : `CIP_ILIM_SRC_LOW;
    end
    if (watchdog_expired) begin
      next_input_ctrl[`CIP_HIZ_BIT] = 1'b0;
    end
    if (register_reset) begin
      next_input_ctrl = `CIP_INPUT_CTRL_RST;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 1; i < `CIP_NUM_REGS; i = i + 1) begin
        regs[i] <= `CIP_OTHER_REG_RST;
      end
      regs[0] <= `CIP_INPUT_CTRL_RST;
      status_pin_disable <= 1'b0;
    end else begin
      regs[0] <= next_input_ctrl;
      for (i = 1; i < `CIP_NUM_REGS; i = i + 1) begin
        if (register_reset) begin
          regs[i] <= `CIP_OTHER_REG_RST;
        end else if (wr_en && wr_addr == i[7:0]) begin
          regs[i] <= wr_data;
        end
      end
      status_pin_disable <= (next_input_ctrl[`CIP_STAT_SEL_MSB:`CIP_STAT_SEL_LSB] == `CIP_STAT_SEL_OFF);
    end
  end

  assign high_impedance_enable = regs[0][`CIP_HIZ_BIT];
  assign status_pin_function_select = regs[0][`CIP_STAT_SEL_MSB:`CIP_STAT_SEL_LSB];
  assign input_current_limit = regs[0][`CIP_ILIM_MSB:`CIP_ILIM_LSB];
endmodule

/* File: tb/cip_i2c_port_props.sv */
`timescale 1ns/1ps
module cip_i2c_port_props (
  input wire mclk,
  input wire rst_n,
  input wire scl_in,
  input wire scl_out,
  input wire scl_oe,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire thermistor_sense_pin,
  input wire [7:0] fault_conditions,
  input wire source_type_pin,
  input wire source_detect_done,
  input wire watchdog_expired,
  input wire register_reset,
  input wire high_impedance_enable,
  input wire [1:0] status_pin_function_select,
  input wire status_pin_disable,
  input wire [4:0] input_current_limit,
  input wire fault_event,
  input wire bus_busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Bus pins.
  // ----------------------------------------------------------------
  a_drive_low: assert property (!scl_out && !sda_out)
    else $error("open drain output level not low");
  a_start_busy: assert property ($fell(sda_in) && scl_in && $past(scl_in) |-> ##[1:5] bus_busy)
    else $error("start not followed by busy");
  a_stop_idle: assert property ($rose(sda_in) && scl_in && $past(scl_in) |-> ##[1:5] !bus_busy)
    else $error("stop not followed by idle");
  a_stretch_len: assert property ($rose(scl_oe) |=> scl_oe [*2] ##[1:4] !scl_oe)
    else $error("clock hold has wrong length");
  a_stretch_low: assert property ($rose(scl_oe) |-> !$past(scl_in))
    else $error("clock hold begun while clock high");
  // Data may only move in the low phase; four high samples cover the synchroniser lag.
  a_data_hold: assert property (scl_in && $past(scl_in) && $past(scl_in, 2)
    && $past(scl_in, 3) |-> $stable(sda_oe))
    else $error("data drive changed while clock high");
  // ----------------------------------------------------------------
  // Input control register and fault events.
  // ----------------------------------------------------------------
  a_status_float: assert property (status_pin_function_select == 2'h3 |-> ##[0:1] status_pin_disable)
    else $error("status pin not disabled for code 3");
  a_status_drive: assert property (status_pin_function_select != 2'h3 ##1
    status_pin_function_select != 2'h3 |-> !status_pin_disable)
    else $error("status pin disabled for other code");
  a_wdog_hiz: assert property (watchdog_expired |=> !high_impedance_enable)
    else $error("watchdog did not clear high impedance");
  a_reg_defaults: assert property (register_reset |=> input_current_limit == 5'h17
    && !high_impedance_enable && status_pin_function_select == 2'h0)
    else $error("register reset did not restore defaults");
  a_src_load: assert property (source_detect_done && !register_reset
    && source_type_pin == $past(source_type_pin, 4) |=> input_current_limit == (source_type_pin ? 5'h04 : 5'h17))
    else $error("source detection loaded wrong limit");
  a_event_cause: assert property (fault_event
    |-> (|$past(fault_conditions[7:1])) || $past(thermistor_sense_pin, 2))
    else $error("fault event without a fault");
  a_event_pulse: assert property (fault_event |=> !fault_event)
    else $error("fault event longer than one cycle");
  cover property (fault_event);
  cover property ($rose(scl_oe));
  cover property (status_pin_disable);
endmodule

bind cip_i2c_port cip_i2c_port_props i_props (.mclk, .rst_n, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out,
  .sda_oe, .thermistor_sense_pin, .fault_conditions, .source_type_pin, .source_detect_done, .watchdog_expired,
  .register_reset, .high_impedance_enable, .status_pin_function_select, .status_pin_disable,
  .input_current_limit, .fault_event, .bus_busy);

/* File: tb/cip_host_model.sv */
`timescale 1ns/1ps
module cip_host_model (
  input wire mclk,
  input wire scl_in,
  input wire sda_in,
  output reg scl_low,
  output reg sda_low,
  output reg [8:0] res,
  output reg res_stb
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    res = 9'h000;
    res_stb = 1'b0;
  end
  task tk(input integer n);
    begin
      repeat (n) @(posedge mclk);
      #1;
    end
  endtask
  // ----------------------------------------------------------------
  // Bit, byte and bus conditions, all clocked by this controller.
  // ----------------------------------------------------------------
  task bit_io(input b, output r);
    integer w;
    begin
      tk(2);
      sda_low = ~b;
      tk(2);
      scl_low = 1'b0;
      w = 0;
      // The target may hold the clock low; the wait is bounded so a stuck target cannot hang us.
      while (scl_in !== 1'b1 && w < 64) begin
        tk(1);
        w = w + 1;
      end
      tk(2);
      r = sda_in;
      tk(2);
      scl_low = 1'b1;
    end
  endtask
  task byte_io(input [8:0] tx);
    integer i;
    reg [8:0] rx;
    begin
      for (i = 8; i >= 0; i = i - 1) bit_io(tx[i], rx[i]);
      res = rx;
      res_stb = 1'b1;
      tk(1);
      res_stb = 1'b0;
    end
  endtask
  task start;
    begin
      tk(2);
      sda_low = 1'b0;
      tk(4);
      scl_low = 1'b0;
      tk(4);
      sda_low = 1'b1;
      tk(4);
      scl_low = 1'b1;
    end
  endtask
  task stop;
    begin
      tk(2);
      sda_low = 1'b1;
      tk(4);
      scl_low = 1'b0;
      tk(4);
      sda_low = 1'b0;
      tk(4);
    end
  endtask
endmodule

/* File: tb/tb_cip_i2c_port.sv */
`timescale 1ns/1ps
module tb_cip_i2c_port;
  reg mclk;
  reg rst_n;
  reg thermistor_sense_pin;
  reg [7:0] fault_conditions;
  reg source_type_pin;
  reg source_detect_done;
  reg watchdog_expired;
  reg register_reset;
  wire scl_out, scl_oe, sda_out, sda_oe, high_impedance_enable, status_pin_disable, fault_event, bus_busy;
  wire [1:0] status_pin_function_select;
  wire [4:0] input_current_limit;
  wire scl_low, sda_low, res_stb;
  wire [8:0] res;
  wire scl_in = (scl_oe ? scl_out : 1'b1) & ~scl_low;
  wire sda_in = (sda_oe ? sda_out : 1'b1) & ~sda_low;
  integer n_mismatch, check_count, cyc, n_evt, c, seed;
  reg [31:0] r32;
  reg [8:0] q[$];
  reg [7:0] ev[0:2];
  cip_i2c_port i_dut (.mclk, .rst_n, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe,
    .thermistor_sense_pin, .fault_conditions, .source_type_pin, .source_detect_done, .watchdog_expired,
    .register_reset, .high_impedance_enable, .status_pin_function_select, .status_pin_disable,
    .input_current_limit, .fault_event, .bus_busy);
  cip_host_model i_host (.mclk, .scl_in, .sda_in, .scl_low, .sda_low, .res, .res_stb);
  always #10 mclk = ~mclk;
  // ----------------------------------------------------------------
  // Checking and closing.
  // ----------------------------------------------------------------
  task cmp_byte(input string nm, input [8:0] e, input [8:0] s);
    begin
      check_count = check_count + 1;
      if (s !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task cmp_out(input string nm, input [8:0] e, input [8:0] s);
    begin
      check_count = check_count + 1;
      if (s !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task end_sim;
    begin
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Each finished byte is matched against the oldest expectation noted by the driver.
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (fault_event === 1'b1) n_evt = n_evt + 1;
    if (res_stb === 1'b1) begin
      if (q.size() == 0) cmp_byte("unexpected byte", ~res, res);
      else cmp_byte("bus byte", q.pop_front(), res);
    end
    if (cyc == 30000) begin
      n_mismatch = n_mismatch + 1;
      end_sim;
    end
  end
  // ----------------------------------------------------------------
  // Transfers.
  // ----------------------------------------------------------------
  task tk(input integer n);
    begin
      repeat (n) @(posedge mclk);
      #1;
    end
  endtask
  task bx(input [8:0] tx, input [8:0] e);
    begin
      q.push_back(e);
      i_host.byte_io(tx);
    end
  endtask
  task adr(input [7:0] ra);
    begin
      i_host.start;
      bx(9'h1ad, 9'h1ac);
      bx({ra, 1'b1}, {ra, 1'b0});
    end
  endtask
  task wr(input [7:0] ra, input integer n);
    integer k;
    begin
      adr(ra);
      for (k = 0; k < n; k = k + 1) bx({ev[k], 1'b1}, {ev[k], 1'b0});
      i_host.stop;
    end
  endtask
  task rd(input [7:0] ra, input integer n);
    integer k;
    begin
      adr(ra);
      i_host.start;
      bx(9'h1af, 9'h1ae);
      for (k = 0; k < n; k = k + 1) bx({8'hff, k == n - 1}, {ev[k], k == n - 1});
      i_host.stop;
    end
  endtask
  task pulse_wd;
    begin
      watchdog_expired = 1'b1;
      tk(1);
      watchdog_expired = 1'b0;
      tk(2);
    end
  endtask
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    thermistor_sense_pin = 1'b0;
    fault_conditions = 8'h00;
    source_type_pin = 1'b0;
    source_detect_done = 1'b0;
    watchdog_expired = 1'b0;
    register_reset = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    cyc = 0;
    n_evt = 0;
    seed = 32'h6b53c843;
    tk(6);
    rst_n = 1'b1;
    tk(4);
    cmp_out("limit", 9'h017, {4'h0, input_current_limit});
    ev[0] = 8'h17;
    rd(8'h00, 1);
    r32 = $random(seed);
    ev[0] = 8'h80;
    ev[1] = r32[7:0];
    ev[2] = r32[15:8];
    wr(8'h00, 3);
    cmp_out("hiz", 9'h001, {8'h00, high_impedance_enable});
    cmp_out("busy", 9'h000, {8'h00, bus_busy});
    rd(8'h00, 3);
    pulse_wd;
    cmp_out("hiz", 9'h000, {8'h00, high_impedance_enable});
    for (c = 0; c < 4; c = c + 1) begin
      ev[0] = {c[1], c[1:0], 5'h0a};
      wr(8'h00, 1);
      tk(2);
      cmp_out("select", c[8:0], {7'h00, status_pin_function_select});
      cmp_out("float", {8'h00, c == 3}, {8'h00, status_pin_disable});
    end
    register_reset = 1'b1;
    tk(1);
    register_reset = 1'b0;
    tk(2);
    cmp_out("limit", 9'h017, {4'h0, input_current_limit});
    cmp_out("select", 9'h000, {7'h00, status_pin_function_select});
    cmp_out("hiz", 9'h000, {8'h00, high_impedance_enable});
    for (c = 0; c < 2; c = c + 1) begin
      source_type_pin = ~c[0];
      tk(6);
      source_detect_done = 1'b1;
      tk(1);
      source_detect_done = 1'b0;
      tk(1);
      cmp_out("limit", c ? 9'h017 : 9'h004, {4'h0, input_current_limit});
    end
    ev[0] = 8'h05;
    wr(8'h00, 1);
    cmp_out("limit", 9'h005, {4'h0, input_current_limit});
    i_host.start;
    cmp_out("busy", 9'h001, {8'h00, bus_busy});
    bx(9'h1a9, 9'h1a9);
    i_host.stop;
    i_host.start;
    bx(9'h1ad, 9'h1ac);
    bx(9'h019, 9'h019);
    i_host.stop;
    ev[0] = 8'h00;
    ev[1] = 8'hff;
    rd(8'h0b, 2);
    rd(8'h08, 2);
    fault_conditions = 8'h40;
    tk(10);
    cmp_out("events", 9'h001, n_evt[8:0]);
    fault_conditions = 8'h60;
    tk(10);
    cmp_out("events", 9'h001, n_evt[8:0]);
    fault_conditions = 8'h00;
    tk(4);
    ev[0] = 8'h60;
    rd(8'h09, 1);
    ev[0] = 8'h00;
    rd(8'h09, 1);
    thermistor_sense_pin = 1'b1;
    tk(10);
    cmp_out("events", 9'h002, n_evt[8:0]);
    ev[0] = 8'h01;
    rd(8'h09, 1);
    thermistor_sense_pin = 1'b0;
    tk(10);
    ev[0] = 8'h00;
    rd(8'h09, 1);
    tk(20);
    end_sim;
  end
endmodule
